//--- srt_pkg.sv
// Package of register map, field positions, reset values and timing counts for the split reload timer
package srt_pkg;

   // ****************************************************************
   // Bus geometry
   // ****************************************************************
   localparam int unsigned SRT_ADDR_W  = 8;              // Byte address width seen by the slave
   localparam int unsigned SRT_DATA_W  = 32;             // Wishbone data width
   localparam int unsigned SRT_BYTE_W  = 8;              // Width of every timer register

   // ****************************************************************
   // Register byte offsets, one aligned word each
   // ****************************************************************
   localparam logic [7:0] SRT_OFF_CTRL   = 8'h00;        // timer_control_reg
   localparam logic [7:0] SRT_OFF_CLKCTL = 8'h04;        // clock_control_reg plus interrupt enable
   localparam logic [7:0] SRT_OFF_RLL    = 8'h08;        // reload_low_byte
   localparam logic [7:0] SRT_OFF_RLH    = 8'h0C;        // reload_high_byte
   localparam logic [7:0] SRT_OFF_CNTL   = 8'h10;        // count_low_byte
   localparam logic [7:0] SRT_OFF_CNTH   = 8'h14;        // count_high_byte

   // ****************************************************************
   // Field positions in timer_control_reg
   // ****************************************************************
   localparam int unsigned SRT_CT_HOVF  = 7;             // high_overflow_flag
   localparam int unsigned SRT_CT_LOVF  = 6;             // low_overflow_flag
   localparam int unsigned SRT_CT_LIEN  = 5;             // low_byte_irq_enable
   localparam int unsigned SRT_CT_CAPEN = 4;             // capture_mode_enable
   localparam int unsigned SRT_CT_SPLIT = 3;             // split_mode_bit
   localparam int unsigned SRT_CT_RUN   = 2;             // run_control_bit
   localparam int unsigned SRT_CT_XCLK  = 0;             // external_clock_select

   // ****************************************************************
   // Field positions in clock control register
   // ****************************************************************
   localparam int unsigned SRT_CK_HSEL  = 7;             // high_byte_clock_select
   localparam int unsigned SRT_CK_LSEL  = 6;             // low_byte_clock_select
   localparam int unsigned SRT_CK_TIEN  = 0;             // Timer interrupt enable

   // Writable bits of each control register; others read zero
   localparam logic [7:0] SRT_CTRL_MASK   = 8'hFD;       // Bit 1 is unused
   localparam logic [7:0] SRT_CLKCTL_MASK = 8'hC1;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [7:0] SRT_RST_BYTE = 8'h00;          // All count, reload and control bytes
   localparam logic [7:0] SRT_ALL_ONES = 8'hFF;          // Byte value that wraps on next tick

   // ****************************************************************
   // Prescaler counts
   // ****************************************************************
   localparam int unsigned SRT_SYS_DIV = 12;             // system_clock divided by 12
   localparam int unsigned SRT_EXT_DIV = 8;              // External oscillator divided by 8
   localparam logic [3:0] SRT_SYS_DIV_LAST = 4'(SRT_SYS_DIV - 1);
   localparam logic [2:0] SRT_EXT_DIV_HALF = 3'(SRT_EXT_DIV / 2);

endpackage : srt_pkg

//--- srt_tick_gen.sv
// Count-source tick generator: divide by 12 and synchronised external oscillator divide by 8
`timescale 1ns/1ps

module srt_tick_gen
   import srt_pkg::*;
(
   input  wire logic clock,                              // System clock
   input  wire logic rst_n,                              // Synchronous reset, active low
   input  wire logic ext_osc,                            // Raw external oscillator
   output logic      sys12_tick,                         // One pulse every 12 clocks
   output logic      ext8_tick                           // Pulse on each falling edge of osc/8
);

   // ****************************************************************
   // Divide by 12 prescaler
   // ****************************************************************
   logic [3:0] div12_q;                                  // Cycle counter 0..11

   // Free running so every divided timer shares one phase
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         div12_q <= 4'h0;
      end else if (div12_q == SRT_SYS_DIV_LAST) begin
         div12_q <= 4'h0;
      end else begin
         div12_q <= div12_q + 4'h1;
      end
   end

   assign sys12_tick = (div12_q == SRT_SYS_DIV_LAST);

   // ****************************************************************
   // External oscillator synchroniser and divide by 8
   // ****************************************************************
   logic       sync1_q;                                  // First stage, read only by sync2_q
   logic       sync2_q;                                  // Second stage, safe to use
   logic       sync3_q;                                  // Delayed copy for edge detect
   logic [2:0] div8_q;                                   // Counts oscillator rising edges
   logic       div8_msb_q;                               // Delayed divided clock

   // Two flops before any logic looks at the oscillator
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         sync3_q <= 1'b0;
      end else begin
         sync1_q <= ext_osc;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   // Oscillator must be below half the system clock or edges drop
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         div8_q     <= 3'h0;
         div8_msb_q <= 1'b0;
      end else begin
         if (sync2_q && !sync3_q) begin
            div8_q <= div8_q + 3'h1;
         end
         div8_msb_q <= div8_q[2];
      end
   end

   // Falling edge of the divided clock
   assign ext8_tick = div8_msb_q && !div8_q[2] && (SRT_EXT_DIV_HALF != 3'h0);

endmodule : srt_tick_gen

//--- srt_timer.sv
// Split reload timer with external oscillator capture and Wishbone register slave
`timescale 1ns/1ps

// How it works
// - Two bytes form one 16-bit counter, two modes
// - Sources: clock, clock/12, synchronised oscillator/8
// - Split bit clear gives one 16-bit timer
// - 16-bit wrap reloads and sets high flag
// - Interrupt on each 16-bit overflow when enabled
// - Low enable adds low byte wrap interrupt
// - Split mode: two 8-bit bytes, own reloads
// - Split mode: run bit gates high byte only
// - Per byte select: clock, else clock/12 or osc/8
// - Split mode: each byte wrap sets its flag
// - Split interrupt: high, or either with enable
// - Flags clear only by software writing zero
// - Capture: low byte counts clock or clock/12 only
// - Osc/8 falling edge copies count, sets flag
// - Capture enable bit switches capture on
// - Low byte wrap sets low flag always
module srt_timer
   import srt_pkg::*;
(
   input  wire logic                  clock,             // System clock, 125 MHz
   input  wire logic                  rst_n,             // Synchronous reset, active low
   input  wire logic                  ext_osc,           // External oscillator input
   input  wire logic                  wb_cyc_i,          // Wishbone cycle
   input  wire logic                  wb_stb_i,          // Wishbone strobe
   input  wire logic                  wb_we_i,           // Wishbone write enable
   input  wire logic [SRT_ADDR_W-1:0] wb_adr_i,          // Wishbone byte address
   input  wire logic [3:0]            wb_sel_i,          // Wishbone byte selects
   input  wire logic [SRT_DATA_W-1:0] wb_dat_i,          // Wishbone write data
   output logic      [SRT_DATA_W-1:0] wb_dat_o,          // Wishbone read data
   output logic                       wb_ack_o,          // Wishbone acknowledge
   output logic                       timer_irq          // Level interrupt request
);

   // ****************************************************************
   // Storage
   // ****************************************************************
   logic [7:0] ctrl_q;                                   // timer_control_reg
   logic [7:0] clkctl_q;                                 // Clock selects and interrupt enable
   logic [7:0] rll_q;                                    // reload_low_byte
   logic [7:0] rlh_q;                                    // reload_high_byte
   logic [7:0] cntl_q;                                   // count_low_byte
   logic [7:0] cnth_q;                                   // count_high_byte
   logic [SRT_DATA_W-1:0] rdata_q;                       // Registered read data
   logic       ack_q;                                    // Registered acknowledge

   // ****************************************************************
   // Decode helpers
   // ****************************************************************
   // Write strike on one register, low lane only
   function automatic logic wr_hit(input logic [7:0] adr, input logic [7:0] off,
                                   input logic req, input logic we, input logic lane0);
      wr_hit = req && we && lane0 && (adr == off);
   endfunction

   logic req_new;                                        // Fresh access not yet acknowledged
   logic wr_ctrl;                                        // Write strikes per register
   logic wr_clk;
   logic wr_rll;
   logic wr_rlh;
   logic wr_cntl;
   logic wr_cnth;

   assign req_new = wb_cyc_i && wb_stb_i && !ack_q;
   assign wr_ctrl = wr_hit(wb_adr_i, SRT_OFF_CTRL, req_new, wb_we_i, wb_sel_i[0]);
   assign wr_clk  = wr_hit(wb_adr_i, SRT_OFF_CLKCTL, req_new, wb_we_i, wb_sel_i[0]);
   assign wr_rll  = wr_hit(wb_adr_i, SRT_OFF_RLL, req_new, wb_we_i, wb_sel_i[0]);
   assign wr_rlh  = wr_hit(wb_adr_i, SRT_OFF_RLH, req_new, wb_we_i, wb_sel_i[0]);
   assign wr_cntl = wr_hit(wb_adr_i, SRT_OFF_CNTL, req_new, wb_we_i, wb_sel_i[0]);
   assign wr_cnth = wr_hit(wb_adr_i, SRT_OFF_CNTH, req_new, wb_we_i, wb_sel_i[0]);

   // ****************************************************************
   // Count sources
   // ****************************************************************
   logic sys12_tick;                                     // Clock/12 pulse
   logic ext8_tick;                                      // Oscillator/8 falling edge pulse

   srt_tick_gen u_ticks (
      .clock      (clock),
      .rst_n      (rst_n),
      .ext_osc    (ext_osc),
      .sys12_tick (sys12_tick),
      .ext8_tick  (ext8_tick)
   );

   // Select table shared by both bytes
   function automatic logic pick_tick(input logic fast, input logic xclk,
                                      input logic t12, input logic t8);
      if (fast) begin
         pick_tick = 1'b1;                               // Every system clock
      end else if (xclk) begin
         pick_tick = t8;
      end else begin
         pick_tick = t12;
      end
   endfunction

   logic split;                                          // Split mode active
   logic run;                                            // Run control
   logic capture;                                        // Capture mode active
   logic tick_l;                                         // Low byte source pulse
   logic tick_h;                                         // High byte source pulse

   assign split   = ctrl_q[SRT_CT_SPLIT];
   assign run     = ctrl_q[SRT_CT_RUN];
   assign capture = ctrl_q[SRT_CT_CAPEN];

   // Capture mode measures the oscillator, so the low byte never counts it
   assign tick_l = capture
                   ? pick_tick(clkctl_q[SRT_CK_LSEL], 1'b0, sys12_tick, ext8_tick)
                   : pick_tick(clkctl_q[SRT_CK_LSEL], ctrl_q[SRT_CT_XCLK], sys12_tick, ext8_tick);
   assign tick_h = pick_tick(clkctl_q[SRT_CK_HSEL], ctrl_q[SRT_CT_XCLK], sys12_tick, ext8_tick);

   // ****************************************************************
   // Advance and wrap decisions
   // ****************************************************************
   logic adv_l;                                          // Low byte steps this cycle
   logic adv_h;                                          // High byte steps this cycle
   logic wrap_l;                                         // Low byte steps while at 0xFF
   logic wrap_h;                                         // High byte or full word wraps
   logic cap_evt;                                        // Capture event

   always_comb begin
      if (split) begin
         adv_l = tick_l;
         adv_h = run && tick_h;
      end else begin
         adv_l = run && tick_l;
         adv_h = run && tick_l && (cntl_q == SRT_ALL_ONES);
      end
   end

   assign wrap_l  = adv_l && (cntl_q == SRT_ALL_ONES);
   assign wrap_h  = adv_h && (cnth_q == SRT_ALL_ONES);
   assign cap_evt = capture && ext8_tick;

   // ****************************************************************
   // Count bytes; a software write wins over counting
   // ****************************************************************
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cntl_q <= SRT_RST_BYTE;
      end else if (wr_cntl) begin
         cntl_q <= wb_dat_i[7:0];
      end else if (split && wrap_l) begin
         cntl_q <= rll_q;
      end else if (!split && wrap_h) begin
         cntl_q <= rll_q;
      end else if (adv_l) begin
         cntl_q <= cntl_q + 8'h01;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cnth_q <= SRT_RST_BYTE;
      end else if (wr_cnth) begin
         cnth_q <= wb_dat_i[7:0];
      end else if (wrap_h) begin
         cnth_q <= rlh_q;
      end else if (adv_h) begin
         cnth_q <= cnth_q + 8'h01;
      end
   end

   // ****************************************************************
   // Reload bytes; capture overrides a same-cycle write
   // ****************************************************************
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rll_q <= SRT_RST_BYTE;
         rlh_q <= SRT_RST_BYTE;
      end else begin
         if (cap_evt) begin
            rll_q <= cntl_q;
         end else if (wr_rll) begin
            rll_q <= wb_dat_i[7:0];
         end
         if (cap_evt) begin
            rlh_q <= cnth_q;
         end else if (wr_rlh) begin
            rlh_q <= wb_dat_i[7:0];
         end
      end
   end

   // ****************************************************************
   // Control registers; hardware set beats software clear
   // ****************************************************************
   logic set_h;                                          // High flag set event
   logic set_l;                                          // Low flag set event

   assign set_h = wrap_h || cap_evt;
   assign set_l = wrap_l;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ctrl_q <= SRT_RST_BYTE;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= wb_dat_i[7:0] & SRT_CTRL_MASK;
         end
         if (set_h) begin
            ctrl_q[SRT_CT_HOVF] <= 1'b1;
         end
         if (set_l) begin
            ctrl_q[SRT_CT_LOVF] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         clkctl_q <= SRT_RST_BYTE;
      end else if (wr_clk) begin
         clkctl_q <= wb_dat_i[7:0] & SRT_CLKCTL_MASK;
      end
   end

   // ****************************************************************
   // Interrupt request from sticky flags
   // ****************************************************************
   // Same form serves both modes: low flag only counts with its enable
   assign timer_irq = clkctl_q[SRT_CK_TIEN]
                      && (ctrl_q[SRT_CT_HOVF]
                          || (ctrl_q[SRT_CT_LIEN] && ctrl_q[SRT_CT_LOVF]));

   // ****************************************************************
   // Wishbone answer: one wait cycle, unmapped reads give zero
   // ****************************************************************
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req_new;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rdata_q <= 32'h0000_0000;
      end else if (req_new && !wb_we_i) begin
         case (wb_adr_i)
            SRT_OFF_CTRL:   rdata_q <= {24'h00_0000, ctrl_q};
            SRT_OFF_CLKCTL: rdata_q <= {24'h00_0000, clkctl_q};
            SRT_OFF_RLL:    rdata_q <= {24'h00_0000, rll_q};
            SRT_OFF_RLH:    rdata_q <= {24'h00_0000, rlh_q};
            SRT_OFF_CNTL:   rdata_q <= {24'h00_0000, cntl_q};
            SRT_OFF_CNTH:   rdata_q <= {24'h00_0000, cnth_q};
            default:        rdata_q <= 32'h0000_0000;
         endcase
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdata_q;

endmodule : srt_timer

//--- srt_timer_asserts.sv
// Concurrent checks on the split reload timer's bus, read data and interrupt ports
`timescale 1ns/1ps

module srt_timer_asserts
   import srt_pkg::*;
(
   input wire logic                  clock,
   input wire logic                  rst_n,
   input wire logic                  ext_osc,
   input wire logic                  wb_cyc_i,
   input wire logic                  wb_stb_i,
   input wire logic                  wb_we_i,
   input wire logic [SRT_ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0]            wb_sel_i,
   input wire logic [SRT_DATA_W-1:0] wb_dat_i,
   input wire logic [SRT_DATA_W-1:0] wb_dat_o,
   input wire logic                  wb_ack_o,
   input wire logic                  timer_irq
);
   // ****************************************************************
   // Helper logic
   // ****************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic req_open;                                       // Request taken at this edge
   logic rd_ctrl_q;                                      // Last taken request read control
   assign req_open = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   // Remember a control read so its answer can be checked a cycle later
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rd_ctrl_q <= 1'b0;
      end else begin
         rd_ctrl_q <= req_open & ~wb_we_i & (wb_adr_i == SRT_OFF_CTRL);
      end
   end
   // ****************************************************************
   // Properties
   // ****************************************************************
   property p_ack_next; req_open |=> wb_ack_o; endproperty
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   property p_idle_no_ack; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
   property p_upper_zero; wb_ack_o |-> (wb_dat_o[31:8] == 24'h000000); endproperty
   property p_unused_bit; wb_ack_o && rd_ctrl_q |-> !wb_dat_o[1]; endproperty
   // Flags only fall by a software write, so the request line must hold meanwhile
   property p_flag_sticky; timer_irq && !(wb_cyc_i && wb_stb_i && wb_we_i) |=> timer_irq; endproperty
   property p_reset_zero; $rose(rst_n) |-> !timer_irq && !wb_ack_o && (wb_dat_o == 32'h00000000); endproperty
   property p_dat_hold; !wb_ack_o |-> $stable(wb_dat_o); endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack missing one cycle after request");
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   a_idle_no_ack: assert property (p_idle_no_ack) else $error("ack without request");
   a_upper_zero: assert property (p_upper_zero) else $error("read data upper bits not zero");
   a_unused_bit: assert property (p_unused_bit) else $error("unused control bit reads one");
   a_flag_sticky: assert property (p_flag_sticky) else $error("interrupt fell without a write");
   a_reset_zero: assert property (p_reset_zero) else $error("outputs not zero after reset");
   a_dat_hold: assert property (p_dat_hold) else $error("read data moved without ack");
   // Main scenarios reached
   c_read_ctrl: cover property (wb_ack_o && rd_ctrl_q);
   c_write: cover property (req_open && wb_we_i);
   c_irq_rise: cover property ($rose(timer_irq));
endmodule // srt_timer_asserts

bind srt_timer srt_timer_asserts u_chk (.clock(clock), .rst_n(rst_n), .ext_osc(ext_osc), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer_irq(timer_irq));

//--- tb_split_reload_timer_with_capture.sv
// Self-checking testbench of the split reload timer over its Wishbone port
`timescale 1ns/1ps

module tb_split_reload_timer_with_capture
   import srt_pkg::*;
;
   // ****************************************************************
   // Signals and model state
   // ****************************************************************
   logic        clock, rst_n, ext_osc, cyc, stb, we, ack, irq;
   logic [7:0]  adr;                                     // Byte address
   logic [3:0]  sel;                                     // Lane selects
   logic [31:0] wdat, rdat, q, h, rl;                    // Bus data and scratch
   logic [2:0]  oc;                                      // Oscillator divider, 8 clocks a period
   logic [31:0] caps[$];                                 // Captured counts in order
   int          fail_count, checked, seed, i;
   int          exp_rl[2];                               // Model of reload bytes

   srt_timer DUT (.clock(clock), .rst_n(rst_n), .ext_osc(ext_osc), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .timer_irq(irq));

   always #4 clock = ~clock;
   // Slow oscillator, far below clock/2 so the synchroniser never misses an edge
   always @(posedge clock) begin
      oc      <= oc + 3'h1;
      ext_osc <= oc[2];
   end
   // ****************************************************************
   // Tasks
   // ****************************************************************
   // One classic cycle; request held until ack is sampled
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
      @(posedge clock);
      while (ack !== 1'b1) @(posedge clock);
      q = rdat;
      cyc <= 1'b0; stb <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Count sources of unknown phase are judged within a window
   task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
      checked++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         fail_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, lo);
      end
   endtask
   // Poll control until a flag shows, bounded
   task automatic poll(input int b);
      int n;
      n = 0;
      xfer(1'b0, SRT_OFF_CTRL, 32'h0);
      while (q[b] !== 1'b1 && n < 300) begin
         xfer(1'b0, SRT_OFF_CTRL, 32'h0);
         n++;
      end
      chk({31'h0, q[b]}, 32'h1);
   endtask
   // Byte pair read high first; not atomic, so only used while stable
   task automatic rd16(input logic [7:0] a);
      xfer(1'b0, a + 8'h04, 32'h0);
      h = q;
      xfer(1'b0, a, 32'h0);
      q = (h << 8) | q;
   endtask
   task automatic tally_and_finish;
      if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // ****************************************************************
   // Sequence
   // ****************************************************************
   initial begin
      clock = 0; rst_n = 0; ext_osc = 0; oc = 0; cyc = 0; stb = 0; we = 0; adr = 0; sel = 0; wdat = 0;
      fail_count = 0; checked = 0; seed = 55549;
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      // Reset values, unmapped word included
      for (i = 0; i < 7; i++) begin
         xfer(1'b0, 8'(i * 4), 32'h0);
         chk(q, 32'h0);
      end
      // Reload bytes read back; unmapped write lost
      for (i = 0; i < 2; i++) begin
         exp_rl[i] = $random(seed) & 255;
         xfer(1'b1, 8'(8 + i * 4), 32'(exp_rl[i]));
         xfer(1'b0, 8'(8 + i * 4), 32'h0);
         chk(q, 32'(exp_rl[i]));
      end
      xfer(1'b1, 8'h18, 32'hA5);
      xfer(1'b0, 8'h18, 32'h0);
      chk(q, 32'h0);
      xfer(1'b1, SRT_OFF_CTRL, 32'hFF);
      xfer(1'b0, SRT_OFF_CTRL, 32'h0);
      chk(q, 32'h000000FD);
      xfer(1'b1, SRT_OFF_CTRL, 32'h0);
      xfer(1'b0, SRT_OFF_CTRL, 32'h0);
      chk(q, 32'h0);
      // 16-bit wrap at full clock rate reloads and flags
      rl = $random(seed) & 32'h7FFF;
      xfer(1'b1, SRT_OFF_CLKCTL, 32'hC1);
      xfer(1'b1, SRT_OFF_RLL, rl & 32'hFF);
      xfer(1'b1, SRT_OFF_RLH, rl >> 8);
      xfer(1'b1, SRT_OFF_CNTL, 32'hFF);
      xfer(1'b1, SRT_OFF_CNTH, 32'hFF);
      xfer(1'b1, SRT_OFF_CTRL, 32'h04);
      poll(SRT_CT_HOVF);
      xfer(1'b1, SRT_OFF_CTRL, 32'hC0);
      repeat (50) @(posedge clock);
      xfer(1'b0, SRT_OFF_CTRL, 32'h0);
      chk(q, 32'hC0);
      chk({31'h0, irq}, 32'h1);
      rd16(SRT_OFF_CNTL);
      chk_rng(q, rl, rl + 40);
      xfer(1'b1, SRT_OFF_CTRL, 32'h0);
      chk({31'h0, irq}, 32'h0);
      // Low byte wrap in 16-bit mode: flag always, interrupt only when enabled
      xfer(1'b1, SRT_OFF_CNTL, 32'hFE);
      xfer(1'b1, SRT_OFF_CNTH, 32'h0);
      xfer(1'b1, SRT_OFF_CTRL, 32'h04);
      poll(SRT_CT_LOVF);
      chk(q & 32'hC0, 32'h40);
      chk({31'h0, irq}, 32'h0);
      xfer(1'b1, SRT_OFF_CTRL, 32'h64);
      chk({31'h0, irq}, 32'h1);
      // Split mode with high byte stopped
      rl = $random(seed) & 32'hFF;
      xfer(1'b1, SRT_OFF_CTRL, 32'h08);
      xfer(1'b1, SRT_OFF_RLL, rl);
      xfer(1'b1, SRT_OFF_CNTL, 32'hFE);
      xfer(1'b1, SRT_OFF_CNTH, 32'hF0);
      repeat (20) @(posedge clock);
      xfer(1'b0, SRT_OFF_CNTH, 32'h0);
      chk(q, 32'hF0);
      xfer(1'b0, SRT_OFF_CTRL, 32'h0);
      chk(q, 32'h48);
      chk({31'h0, irq}, 32'h0);
      xfer(1'b0, SRT_OFF_CNTL, 32'h0);
      chk_rng(q, rl, 255);
      xfer(1'b1, SRT_OFF_CTRL, 32'h4C);
      poll(SRT_CT_HOVF);
      chk({31'h0, irq}, 32'h1);
      // Slow sources on the low byte: clock/12, then oscillator/8
      xfer(1'b1, SRT_OFF_CLKCTL, 32'h80);
      for (i = 0; i < 2; i++) begin
         xfer(1'b1, SRT_OFF_CTRL, 32'(8 + i));
         xfer(1'b1, SRT_OFF_CNTL, 32'h0);
         repeat (i ? 640 : 120) @(posedge clock);
         xfer(1'b0, SRT_OFF_CNTL, 32'h0);
         chk_rng(q, 9, 11);
      end
      // Capture: two successive captures lie one oscillator/8 period apart
      xfer(1'b1, SRT_OFF_CTRL, 32'h0);
      xfer(1'b1, SRT_OFF_CLKCTL, 32'h40);
      xfer(1'b1, SRT_OFF_CNTL, 32'h0);
      xfer(1'b1, SRT_OFF_CNTH, 32'h0);
      for (i = 0; i < 2; i++) begin
         xfer(1'b1, SRT_OFF_CTRL, 32'h14);
         poll(SRT_CT_HOVF);
         rd16(SRT_OFF_RLL);
         caps.push_back(q);
      end
      chk((caps[1] - caps[0]) & 32'hFFFF, 32'd64);
      tally_and_finish();
   end
   // Watchdog well beyond the thousand or so cycles the sequence needs
   initial begin
      repeat (20000) @(posedge clock);
      fail_count++;
      tally_and_finish();
   end
endmodule // tb_split_reload_timer_with_capture
